// *** src/avg_accum.sv ***
// Per-sample power calculation and averaging accumulators.
// Assumes add pulses never coincide with load or clear.
`timescale 1ns/1ns
`default_nettype none
module avg_accum (
    input wire logic clk,
    input wire logic rst_n,
    avg_if.acc       a
);
    localparam int W = pwrmon_pkg::ACC_W;
    logic signed [W-1:0] acc_cur;
    logic        [W-1:0] acc_bus;
    logic        [W-1:0] acc_pwr;
    logic signed [15:0]  cur_hold;
    logic        [15:0]  cur_avg;
    logic        [15:0]  bus_avg;
    logic        [15:0]  pwr_avg;
    logic signed [W-1:0] next_acc_cur;
    logic        [W-1:0] next_acc_bus;
    logic        [W-1:0] next_acc_pwr;
    logic signed [15:0]  next_cur_hold;
    logic        [15:0]  next_cur_avg;
    logic        [15:0]  next_bus_avg;
    logic        [15:0]  next_pwr_avg;

    // Magnitude of current times voltage, scaled and saturated
    function automatic logic [15:0] pwr_calc(input logic signed [15:0] i, input logic [15:0] v);
        logic [16:0] mag;
        logic [32:0] prod;
        mag  = i[15] ? 17'(-$signed({i[15], i})) : {1'b0, i};
        prod = (33'(mag) * 33'(v)) / 33'(pwrmon_pkg::PWR_DIVISOR);
        return (prod > 33'h0_0000_FFFF) ? 16'hFFFF : prod[15:0];
    endfunction

    assign a.power_sample = pwr_calc(cur_hold, a.bus_sample);
    assign a.current_avg  = cur_avg;
    assign a.bus_avg      = bus_avg;
    assign a.power_avg    = pwr_avg;

    // ========================================
    // Accumulate and load
    always_comb begin
        next_acc_cur  = acc_cur;
        next_acc_bus  = acc_bus;
        next_acc_pwr  = acc_pwr;
        next_cur_hold = cur_hold;
        next_cur_avg  = cur_avg;
        next_bus_avg  = bus_avg;
        next_pwr_avg  = pwr_avg;
        if (a.load) begin
            if (a.load_current)
                next_cur_avg = 16'(acc_cur >>> a.avg_log2);
            if (a.load_bus) begin
                next_bus_avg = 16'(acc_bus >> a.avg_log2);
                next_pwr_avg = 16'(acc_pwr >> a.avg_log2);
            end
        end
        if (a.clear || a.load) begin
            next_acc_cur = '0;
            next_acc_bus = '0;
            next_acc_pwr = '0;
        end else begin
            if (a.add_current) begin
                next_cur_hold = a.current_sample;
                next_acc_cur  = acc_cur + W'(a.current_sample);
            end
            if (a.add_bus) begin
                next_acc_bus = acc_bus + W'(a.bus_sample);
                next_acc_pwr = acc_pwr + W'(a.power_sample);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_cur  <= '0;
            acc_bus  <= '0;
            acc_pwr  <= '0;
            cur_hold <= '0;
            cur_avg  <= '0;
            bus_avg  <= '0;
            pwr_avg  <= '0;
        end else begin
            acc_cur  <= next_acc_cur;
            acc_bus  <= next_acc_bus;
            acc_pwr  <= next_acc_pwr;
            cur_hold <= next_cur_hold;
            cur_avg  <= next_cur_avg;
            bus_avg  <= next_bus_avg;
            pwr_avg  <= next_pwr_avg;
        end
    end

    // ========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_neg_current: assert property (
        (a.load && a.load_current && a.avg_log2 == 3'h0 && acc_cur < 0 && acc_cur >= -32768)
        |=> cur_avg[15]) else $error("negative current not reported negative");
    chk_power_sign: assert property (
        (cur_hold <= -16'sd6400 && a.bus_sample != 16'h0000) |-> a.power_sample != 16'h0000)
        else $error("power lost for negative current");
    chk_single_avg: assert property (
        (a.load && a.load_bus && a.avg_log2 == 3'h0 && acc_bus < 24'h01_0000)
        |=> bus_avg == $past(acc_bus[15:0])) else $error("single sample not loaded directly");
endmodule
`default_nettype wire

// *** src/avg_if.sv ***
// Link between the sequencer and the averaging accumulator.
// Assumes both ends share one clock.
`timescale 1ns/1ns
`default_nettype none
interface avg_if;
    logic               clear;
    logic               add_current;
    logic               add_bus;
    logic               load;
    logic               load_current;
    logic               load_bus;
    logic signed [15:0] current_sample;
    logic        [15:0] bus_sample;
    logic        [2:0]  avg_log2;
    logic        [15:0] power_sample;
    logic        [15:0] current_avg;
    logic        [15:0] bus_avg;
    logic        [15:0] power_avg;
    modport seq (output clear, add_current, add_bus, load, load_current, load_bus,
                 output current_sample, bus_sample, avg_log2,
                 input power_sample, current_avg, bus_avg, power_avg);
    modport acc (input clear, add_current, add_bus, load, load_current, load_bus,
                 input current_sample, bus_sample, avg_log2,
                 output power_sample, current_avg, bus_avg, power_avg);
endinterface
`default_nettype wire

// *** src/pwrmon_core.sv ***
// Sequencer, register file and alert logic of the current and power monitor.
// Assumes a serial bus decoder that drives the register port on this clock
// and ADC results that are stable when a conversion period ends.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Current and power computed in background, adding no conversion time.
// - Per-sample current and power summed in accumulator, also when averaging one.
// - Bus voltage summed too; averages then loaded to output registers.
// - One alert limit register at pointer 07h.
// - Five alert functions; highest enabled bit wins.
// - Open-drain alert asserted when monitored quantity exceeds (over) or falls below (under) the limit.
// - Ready may share alert pin; host reads bits 3 and 4 for source.
// - Without ready enable, alert pin follows only the limit function.
// - Over-current compared to limit after every shunt conversion.
// - Function flag set on violation; pin level follows polarity bit 1.
// - Latched flag and pin held until config write or mask read.
// - Bus over/under voltage compared after every bus conversion.
// - Power compared to limit after every bus conversion.
// - Shunt and bus conversion times set separately, 140 us to 8.244 ms.
// - Current 01h, bus voltage 02h, power 03h at fixed resolutions.
// - Reverse current reported negative in two's complement.
// - Power result always non-negative.
// - Mode 111 converts continuously once written (idle after reset); 001-011 one shot per config write.
// - Ready flag set on completion; cleared by active config write or mask read.
module pwrmon_core #(
    parameter int CT_MAX_CYCLES = pwrmon_pkg::CT_MAX_CYCLES,
    parameter int CT_MIN_CYCLES = pwrmon_pkg::CT_MIN_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_ptr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output var  logic [15:0] reg_rdata,
    input  wire logic [15:0] adc_current,
    input  wire logic [15:0] adc_bus,
    output var  logic        shunt_busy,
    output var  logic        bus_busy,
    output var  logic        alert_out,
    output var  logic        alert_oe
);
    typedef logic [pwrmon_pkg::CNT_W-1:0] cnt_type;

    avg_if av ();
    avg_accum u_acc (
        .clk   (clk),
        .rst_n (rst_n),
        .a     (av.acc)
    );

    // ========================================
    // Helpers
    function automatic cnt_type ct_cycles(input logic [2:0] code);
        longint span;
        span = longint'(CT_MAX_CYCLES - CT_MIN_CYCLES) * longint'(code) / 64'sd7;
        return cnt_type'(longint'(CT_MIN_CYCLES) + span - 64'sd1);
    endfunction

    function automatic pwrmon_pkg::alert_fn_type fn_pick(input logic [15:0] m);
        if (m[pwrmon_pkg::MSK_OVC])      return pwrmon_pkg::FN_OVC;
        else if (m[pwrmon_pkg::MSK_UNC]) return pwrmon_pkg::FN_UNC;
        else if (m[pwrmon_pkg::MSK_BOV]) return pwrmon_pkg::FN_BOV;
        else if (m[pwrmon_pkg::MSK_BUV]) return pwrmon_pkg::FN_BUV;
        else if (m[pwrmon_pkg::MSK_PWO]) return pwrmon_pkg::FN_PWO;
        else                             return pwrmon_pkg::FN_NONE;
    endfunction

    function automatic pwrmon_pkg::seq_state_type first_st(input logic [2:0] md);
        return md[0] ? pwrmon_pkg::ST_SHUNT : pwrmon_pkg::ST_BUS;
    endfunction

    // ========================================
    // Registers
    logic [15:0] configuration;
    logic [15:0] alert_threshold;
    logic [15:0] mask_en;
    logic        fn_flag;
    logic        rdy_flag;
    logic [15:0] next_configuration;
    logic [15:0] next_alert_threshold;
    logic [15:0] next_mask_en;
    logic [15:0] next_rdata;

    logic [2:0] mode;
    logic       cfg_wr;
    logic       msk_rd;
    assign mode   = configuration[pwrmon_pkg::CFG_MODE_LSB +: 3];
    assign cfg_wr = reg_wr && reg_ptr == pwrmon_pkg::PTR_CFG;
    assign msk_rd = reg_rd && reg_ptr == pwrmon_pkg::PTR_MSK;

    always_comb begin
        next_configuration   = configuration;
        next_alert_threshold = alert_threshold;
        next_mask_en         = mask_en;
        next_rdata           = reg_rdata;
        if (reg_wr) begin
            case (reg_ptr)
                pwrmon_pkg::PTR_CFG: next_configuration = reg_wdata;
                pwrmon_pkg::PTR_LIM: next_alert_threshold = reg_wdata;
                pwrmon_pkg::PTR_MSK: next_mask_en = reg_wdata & pwrmon_pkg::MSK_WMASK;
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_ptr)
                pwrmon_pkg::PTR_CFG: next_rdata = configuration;
                pwrmon_pkg::PTR_CUR: next_rdata = av.current_avg;
                pwrmon_pkg::PTR_BUS: next_rdata = av.bus_avg;
                pwrmon_pkg::PTR_PWR: next_rdata = av.power_avg;
                pwrmon_pkg::PTR_MSK: begin
                    next_rdata = mask_en;
                    next_rdata[pwrmon_pkg::MSK_FNF]  = fn_flag;
                    next_rdata[pwrmon_pkg::MSK_RDYF] = rdy_flag;
                end
                pwrmon_pkg::PTR_LIM: next_rdata = alert_threshold;
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            configuration   <= pwrmon_pkg::CFG_RESET;
            alert_threshold <= pwrmon_pkg::LIM_RESET;
            mask_en         <= pwrmon_pkg::MSK_RESET;
            reg_rdata       <= 16'h0000;
        end else begin
            configuration   <= next_configuration;
            alert_threshold <= next_alert_threshold;
            mask_en         <= next_mask_en;
            reg_rdata       <= next_rdata;
        end
    end

    // ========================================
    // Conversion sequencer
    pwrmon_pkg::seq_state_type state;
    pwrmon_pkg::seq_state_type next_state;
    cnt_type    cnt;
    cnt_type    next_cnt;
    logic [6:0] nsamp;
    logic [6:0] next_nsamp;
    logic       shunt_done;
    logic       bus_done;
    logic [2:0] avg_log2;

    assign avg_log2   = configuration[pwrmon_pkg::CFG_AVG_LSB +: 3];
    assign shunt_done = state == pwrmon_pkg::ST_SHUNT
                        && cnt == ct_cycles(configuration[pwrmon_pkg::CFG_SCT_LSB +: 3]);
    assign bus_done   = state == pwrmon_pkg::ST_BUS
                        && cnt == ct_cycles(configuration[pwrmon_pkg::CFG_BCT_LSB +: 3]);

    assign av.clear          = cfg_wr;
    assign av.add_current    = shunt_done;
    assign av.add_bus        = bus_done;
    assign av.current_sample = adc_current;
    assign av.bus_sample     = adc_bus;
    assign av.avg_log2       = avg_log2;
    assign av.load_current   = mode[0];
    assign av.load_bus       = mode[1];
    assign av.load           = state == pwrmon_pkg::ST_SUM
                               && nsamp == 7'((8'h01 << avg_log2) - 8'h01);

    always_comb begin
        next_state = state;
        next_cnt   = cnt + cnt_type'(1);
        next_nsamp = nsamp;
        case (state)
            pwrmon_pkg::ST_IDLE: next_cnt = '0;
            pwrmon_pkg::ST_SHUNT: begin
                if (shunt_done) begin
                    next_cnt   = '0;
                    next_state = mode[1] ? pwrmon_pkg::ST_BUS : pwrmon_pkg::ST_SUM;
                end
            end
            pwrmon_pkg::ST_BUS: begin
                if (bus_done) begin
                    next_cnt   = '0;
                    next_state = pwrmon_pkg::ST_SUM;
                end
            end
            pwrmon_pkg::ST_SUM: begin
                next_cnt   = '0;
                next_nsamp = nsamp + 7'h01;
                next_state = first_st(mode);
                if (av.load) begin
                    next_nsamp = 7'h00;
                    if (!mode[2])
                        next_state = pwrmon_pkg::ST_IDLE;
                end
            end
            default: next_state = pwrmon_pkg::ST_IDLE;
        endcase
        if (cfg_wr) begin
            next_cnt   = '0;
            next_nsamp = 7'h00;
            if (reg_wdata[1:0] != 2'b00)
                next_state = first_st(reg_wdata[2:0]);
            else
                next_state = pwrmon_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state      <= pwrmon_pkg::ST_IDLE;
            cnt        <= '0;
            nsamp      <= 7'h00;
            shunt_busy <= 1'b0;
            bus_busy   <= 1'b0;
        end else begin
            state      <= next_state;
            cnt        <= next_cnt;
            nsamp      <= next_nsamp;
            shunt_busy <= next_state == pwrmon_pkg::ST_SHUNT;
            bus_busy   <= next_state == pwrmon_pkg::ST_BUS;
        end
    end

    // ========================================
    // Alert unit
    pwrmon_pkg::alert_fn_type fn;
    logic viol;
    logic check;
    logic fn_flag_clr;
    logic alert_on;
    logic next_fn_flag;
    logic next_rdy_flag;
    logic next_oe;
    assign fn = fn_pick(mask_en);

    always_comb begin
        viol  = 1'b0;
        check = 1'b0;
        case (fn)
            pwrmon_pkg::FN_OVC: begin
                check = shunt_done;
                viol  = $signed(adc_current) > $signed(alert_threshold);
            end
            pwrmon_pkg::FN_UNC: begin
                check = shunt_done;
                viol  = $signed(adc_current) < $signed(alert_threshold);
            end
            pwrmon_pkg::FN_BOV: begin
                check = bus_done;
                viol  = adc_bus > alert_threshold;
            end
            pwrmon_pkg::FN_BUV: begin
                check = bus_done;
                viol  = adc_bus < alert_threshold;
            end
            pwrmon_pkg::FN_PWO: begin
                check = bus_done;
                viol  = av.power_sample > alert_threshold;
            end
            default: ;
        endcase
        viol = viol && check;
        if (mask_en[pwrmon_pkg::MSK_LEN])
            fn_flag_clr = cfg_wr || msk_rd;
        else
            fn_flag_clr = check || msk_rd;
        next_fn_flag  = viol || (fn_flag && !fn_flag_clr);
        next_rdy_flag = av.load || (rdy_flag && !((cfg_wr && reg_wdata[1:0] != 2'b00) || msk_rd));
        alert_on      = next_fn_flag || (mask_en[pwrmon_pkg::MSK_RDY_EN] && next_rdy_flag);
        next_oe       = alert_on ^ mask_en[pwrmon_pkg::MSK_PLR];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fn_flag   <= 1'b0;
            rdy_flag  <= 1'b0;
            alert_oe  <= 1'b0;
            alert_out <= 1'b0;
        end else begin
            fn_flag   <= next_fn_flag;
            rdy_flag  <= next_rdy_flag;
            alert_oe  <= next_oe;
            alert_out <= 1'b0;
        end
    end

    // ========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_ready_set: assert property (av.load |=> rdy_flag)
        else $error("ready flag not set on completion");
    chk_ready_clear: assert property ((msk_rd && !av.load) |=> !rdy_flag)
        else $error("ready flag survived mask read");
    chk_fn_priority: assert property (
        (mask_en[pwrmon_pkg::MSK_OVC] && mask_en[pwrmon_pkg::MSK_UNC] && !mask_en[pwrmon_pkg::MSK_LEN]
         && shunt_done && $signed(adc_current) < $signed(alert_threshold) && !msk_rd && !reg_wr)
        |=> !fn_flag) else $error("lower priority function acted");
    chk_over_current: assert property (
        (fn == pwrmon_pkg::FN_OVC && shunt_done && $signed(adc_current) > $signed(alert_threshold))
        |=> fn_flag) else $error("over-current missed");
    chk_bus_under: assert property (
        (fn == pwrmon_pkg::FN_BUV && bus_done && adc_bus < alert_threshold) |=> fn_flag)
        else $error("bus under-voltage missed");
    chk_power_over: assert property (
        (fn == pwrmon_pkg::FN_PWO && bus_done && av.power_sample > alert_threshold) |=> fn_flag)
        else $error("power over-limit missed");
    chk_latch_hold: assert property (
        (mask_en[pwrmon_pkg::MSK_LEN] && fn_flag && !cfg_wr && !msk_rd) |=> fn_flag)
        else $error("latched flag dropped");
    chk_pin_quiet: assert property (
        (!mask_en[pwrmon_pkg::MSK_RDY_EN] && !next_fn_flag && !reg_wr)
        |=> alert_oe == mask_en[pwrmon_pkg::MSK_PLR])
        else $error("pin asserted without limit event");
    chk_pin_follow: assert property (
        (fn_flag && !$past(reg_wr)) |-> alert_oe == !mask_en[pwrmon_pkg::MSK_PLR])
        else $error("pin not asserted with flag");
    chk_one_shot: assert property (
        (cfg_wr && reg_wdata[2:0] == 3'b011) |=> state == pwrmon_pkg::ST_SHUNT ##1 shunt_busy)
        else $error("single shot not started");
    chk_no_stall: assert property (bus_done && !cfg_wr |=> state == pwrmon_pkg::ST_SUM)
        else $error("calculation added time");
    cov_load: cover property (av.load ##1 rdy_flag);
    cov_latch: cover property (mask_en[pwrmon_pkg::MSK_LEN] && fn_flag ##1 msk_rd);
    cov_idle: cover property (av.load && !mode[2] ##1 state == pwrmon_pkg::ST_IDLE);
endmodule
`default_nettype wire

// *** src/pwrmon_pkg.sv ***
// Constants shared by the power monitor back end.
// Assumes a 25 MHz core clock.
package pwrmon_pkg;
    // ========================================
    // Register pointers
    localparam logic [7:0] PTR_CFG = 8'h00;
    localparam logic [7:0] PTR_CUR = 8'h01;
    localparam logic [7:0] PTR_BUS = 8'h02;
    localparam logic [7:0] PTR_PWR = 8'h03;
    localparam logic [7:0] PTR_MSK = 8'h06;
    localparam logic [7:0] PTR_LIM = 8'h07;
    // ========================================
    // Configuration fields
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_SCT_LSB  = 3;
    localparam int CFG_BCT_LSB  = 6;
    localparam int CFG_AVG_LSB  = 9;
    localparam logic [15:0] CFG_RESET = 16'h0127;
    localparam logic [15:0] MSK_RESET = 16'h0000;
    localparam logic [15:0] LIM_RESET = 16'h0000;
    // ========================================
    // Mask/enable fields
    localparam int MSK_OVC    = 15;
    localparam int MSK_UNC    = 14;
    localparam int MSK_BOV    = 13;
    localparam int MSK_BUV    = 12;
    localparam int MSK_PWO    = 11;
    localparam int MSK_RDY_EN = 10;
    localparam int MSK_FNF    = 4;
    localparam int MSK_RDYF   = 3;
    localparam int MSK_PLR    = 1;
    localparam int MSK_LEN  = 0;
    localparam logic [15:0] MSK_WMASK = 16'hFC03;
    // ========================================
    // Timing
    localparam int CLK_MHZ       = 25;
    localparam int CT_MIN_TIME_US = 140;
    localparam int CT_MAX_TIME_US = 8244;
    localparam int CT_MIN_CYCLES = CT_MIN_TIME_US * CLK_MHZ;
    localparam int CT_MAX_CYCLES = CT_MAX_TIME_US * CLK_MHZ;
    localparam int CNT_W         = 18;
    // ========================================
    // Arithmetic
    localparam int ACC_W       = 24;
    localparam int PWR_DIVISOR = 6400;
    // ========================================
    // Types
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHUNT = 2'b01,
        ST_BUS   = 2'b10,
        ST_SUM   = 2'b11
    } seq_state_type;
    typedef enum logic [2:0] {
        FN_NONE = 3'b000,
        FN_OVC  = 3'b001,
        FN_UNC  = 3'b010,
        FN_BOV  = 3'b011,
        FN_BUV  = 3'b100,
        FN_PWO  = 3'b101
    } alert_fn_type;
endpackage

// *** tb/host_model.sv ***
// Host side of the register port, one access per task call.
// Assumes calls start just after a falling clock edge.
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input  wire logic        clk,
    input  wire logic [15:0] rdata,
    output var  logic [7:0]  ptr,
    output var  logic        wr,
    output var  logic        rd,
    output var  logic [15:0] wdata
);
    initial begin
        ptr = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 16'h0000;
    end
    // ========================================
    // One strobe, then released data turns over
    task automatic access(input logic [7:0] p, input logic w, input logic [15:0] d, output logic [15:0] q);
        ptr = p;
        wr = w;
        rd = !w;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b0;
        wdata = ~d;
        @(negedge clk);
        q = rdata;
    endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the power monitor core.
// Assumes shortened conversion counts.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        clk;
    logic        rst_n;
    logic [15:0] adc_current;
    logic [15:0] adc_bus;
    logic [7:0]  ptr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        shunt_busy;
    logic        bus_busy;
    logic        alert_out;
    logic        alert_oe;
    int          error_cnt;
    int          checks;
    int          cyc;
    pwrmon_core #(.CT_MAX_CYCLES(70), .CT_MIN_CYCLES(7)) dut (.clk(clk), .rst_n(rst_n), .reg_ptr(ptr),
        .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata), .adc_current(adc_current),
        .adc_bus(adc_bus), .shunt_busy(shunt_busy), .bus_busy(bus_busy), .alert_out(alert_out),
        .alert_oe(alert_oe));
    host_model host (.clk(clk), .rdata(rdata), .ptr(ptr), .wr(wr), .rd(rd), .wdata(wdata));
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic convert(input logic [15:0] cfg);
        logic [15:0] q;
        int          n;
        host.access(pwrmon_pkg::PTR_CFG, 1'b1, cfg, q);
        n = 0;
        while (bus_busy !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        while (bus_busy !== 1'b0 && n < 300) begin
            @(negedge clk);
            n++;
        end
        repeat (3) @(negedge clk);
    endtask
    // ========================================
    // Scenarios
    task automatic test_results();
        logic [15:0] q;
        adc_current = 16'hFF9C;
        adc_bus = 16'h1900;
        convert(16'h0003);
        host.access(pwrmon_pkg::PTR_CUR, 1'b0, 16'h0000, q);
        check("current", 16'hFF9C, q);
        host.access(pwrmon_pkg::PTR_BUS, 1'b0, 16'h0000, q);
        check("bus", 16'h1900, q);
        host.access(pwrmon_pkg::PTR_PWR, 1'b0, 16'h0000, q);
        check("power", 16'h0064, q);
        host.access(pwrmon_pkg::PTR_MSK, 1'b0, 16'h0000, q);
        check("ready", 16'h0008, q);
        host.access(pwrmon_pkg::PTR_MSK, 1'b0, 16'h0000, q);
        check("ready clear", 16'h0000, q);
    endtask
    task automatic test_alert();
        logic [15:0] q;
        logic [15:0] mk [5] = '{16'h8000, 16'h8000, 16'h4000, 16'hC000, 16'h8002};
        logic [15:0] cu [5] = '{16'h0020, 16'h0005, 16'h0005, 16'h0005, 16'h0020};
        logic        af [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        host.access(pwrmon_pkg::PTR_LIM, 1'b0, 16'h0000, q);
        host.access(pwrmon_pkg::PTR_LIM, 1'b1, 16'h0010, q);
        for (int i = 0; i < 5; i++) begin
            adc_current = cu[i];
            host.access(pwrmon_pkg::PTR_MSK, 1'b1, mk[i], q);
            convert(16'h0003);
            check("alert pin", {15'h0000, af[i] ^ mk[i][1]}, {15'h0000, alert_oe});
            check("alert data", 16'h0000, {15'h0000, alert_out});
            host.access(pwrmon_pkg::PTR_MSK, 1'b0, 16'h0000, q);
            check("flags", mk[i] | {11'h000, af[i], 4'h8}, q);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        cyc = 0;
        forever begin
            @(posedge clk);
            cyc++;
            if (cyc == 3000) begin
                error_cnt++;
                end_of_test();
            end
        end
    end
    initial begin
        error_cnt = 0;
        checks = 0;
        rst_n = 1'b0;
        adc_current = 16'h0000;
        adc_bus = 16'h0000;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        test_results();
        test_alert();
        end_of_test();
    end
endmodule
`default_nettype wire
